// >>> rtl/abu_pkg.sv
// Package of constants, types and decode helpers for the breakpoint unit.
package abu_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int INT_W = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_BP_HIGH = 16'hFE0C;
    localparam logic [15:0] IDX_BP_LOW = 16'hFE0D;
    localparam logic [15:0] IDX_STATUS_CTRL = 16'hFE0E;
    localparam logic [15:0] IDX_FLAG_CTRL = 16'hFE10;
    localparam logic [15:0] IDX_INT_STATUS = 16'hFE11;
    localparam logic [15:0] IDX_INT_MASK = 16'hFE12;

    localparam int SCR_ENABLE_BIT = 7;
    localparam int SCR_ACTIVE_BIT = 6;
    localparam int FLAG_CLEAR_EN_BIT = 7;
    localparam int INT_MATCH_BIT = 0;
    localparam int INT_SOFT_BIT = 1;
    localparam int INT_END_BIT = 2;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [INT_W-1:0] RST_INT = 3'h0;
    localparam logic [15:0] VEC_USER = 16'hFFFC;
    localparam logic [15:0] VEC_MONITOR = 16'hFEFC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PENDING = 3'b010,
        ST_ACTIVE = 3'b100
    } abu_state_t;

    // Core-side view: fetch address and instruction boundary markers.
    typedef struct packed {
        logic [15:0] addr;
        logic addr_valid;
        logic instr_last;
        logic rti_exec;
    } abu_cpu_t;

    // Mode inputs from the system integration unit and pads.
    typedef struct packed {
        logic monitor_mode;
        logic hv_reset_pin;
        logic low_power;
    } abu_sys_t;

    // Outputs toward the system integration unit, timer and watchdog.
    typedef struct packed {
        logic breakpoint_request;
        logic load_soft_int;
        logic [15:0] vector_addr;
        logic break_state;
        logic timer_stop;
        logic watchdog_disable;
        logic flag_clear_allowed;
        logic wake_request;
        logic break_wakeup_flag_set;
    } abu_sys_out_t;

    function automatic logic reg_hit(logic [ADDR_W-1:0] a, logic [15:0] idx);
        reg_hit = (a == {idx, 2'b00});
    endfunction
endpackage

// >>> rtl/abu_addr_cmp.sv
// Full-width comparator of the fetch address against the breakpoint.
module abu_addr_cmp (
    input wire abu_pkg::abu_cpu_t cpu,
    input wire logic [15:0] bp_addr,
    input wire logic enable,
    output logic match
);
    // Only program-counter fetches are presented with addr_valid, so data
    // accesses to the same address never trip the breakpoint.
    always_comb begin
        match = enable && cpu.addr_valid && (cpu.addr == bp_addr);
    end
endmodule

// >>> rtl/abu_break_seq.sv
// Break sequencer: waits for the instruction boundary and tracks the break.
module abu_break_seq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic trigger,
    input wire abu_pkg::abu_cpu_t cpu,
    input wire abu_pkg::abu_sys_t sys,
    output logic load_soft_int,
    output logic in_break,
    output logic request,
    output logic break_end
);
    abu_pkg::abu_state_t st_r;
    abu_pkg::abu_state_t st_nxt;
    logic boundary;

    // A sleeping core runs no instruction, so the break may start at once.
    assign boundary = cpu.instr_last || sys.low_power;

    always_comb begin
        st_nxt = st_r;
        load_soft_int = 1'b0;
        break_end = 1'b0;
        case (st_r)
            abu_pkg::ST_IDLE: begin
                if (trigger && boundary) begin
                    load_soft_int = 1'b1;
                    st_nxt = abu_pkg::ST_ACTIVE;
                end else if (trigger) begin
                    st_nxt = abu_pkg::ST_PENDING;
                end
            end
            abu_pkg::ST_PENDING: begin
                if (boundary) begin
                    load_soft_int = 1'b1;
                    st_nxt = abu_pkg::ST_ACTIVE;
                end
            end
            abu_pkg::ST_ACTIVE: begin
                if (cpu.rti_exec) begin
                    break_end = 1'b1;
                    st_nxt = abu_pkg::ST_IDLE;
                end
            end
            default: st_nxt = abu_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= abu_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_break = (st_r == abu_pkg::ST_ACTIVE);
    assign request = trigger || (st_r == abu_pkg::ST_PENDING);
endmodule

// >>> rtl/abu_top.sv
// Address breakpoint unit with AXI4-Lite registers and break control.
//
// Summary of operation
// - With matching enabled, an address equal to the breakpoint raises the request.
// - Only program-counter fetch addresses are compared, over all sixteen bits.
// - A request loads the soft interrupt opcode after the current instruction.
// - Break vector is FFFC/FFFD in user mode, FEFC/FEFD in monitor mode.
// - A match on an instruction's last cycle starts the break at once.
// - Hardware sets the break-active bit on every breakpoint address match.
// - Software writing one to break-active starts a break without any match.
// - Writing zero clears break-active; reset clears it too.
// - Match enable is read/write bit 7; zero or reset disables matching.
// - Two byte registers hold the breakpoint address halves; reset clears both.
// - Status/control: bit 7 enable, bit 6 active, bits 5 to 0 read zero.
// - The interrupt-return opcode in the break routine ends the break.
// - The timer counter is held stopped while a break is in progress.
// - During a break the watchdog is disabled when reset-pin high voltage exists.
// - During break, status flags clear only when the flag-clear enable is set.
// - A break wakes the device from wait or stop and sets wakeup flag.
// - Flag-clear enable is read/write; one allows, zero blocks clearing in break.
//
// The AXI4-Lite interface to the registers is this design's own decision.
module abu_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [abu_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [abu_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [abu_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [abu_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire abu_pkg::abu_cpu_t cpu,
    input wire abu_pkg::abu_sys_t sys,
    output abu_pkg::abu_sys_out_t sys_out,
    output logic irq
);
    // Write channel capture state.
    logic aw_have_r;
    logic aw_have_nxt;
    logic [abu_pkg::ADDR_W-1:0] aw_addr_r;
    logic [abu_pkg::ADDR_W-1:0] aw_addr_nxt;
    logic w_have_r;
    logic w_have_nxt;
    logic [7:0] w_data_r;
    logic [7:0] w_data_nxt;
    logic w_lane_r;
    logic w_lane_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    // Read channel state.
    logic rvalid_r;
    logic rvalid_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // Software-visible registers.
    logic [7:0] bp_high_r;
    logic [7:0] bp_high_nxt;
    logic [7:0] bp_low_r;
    logic [7:0] bp_low_nxt;
    logic enable_r;
    logic enable_nxt;
    logic active_r;
    logic active_nxt;
    logic clear_en_r;
    logic clear_en_nxt;
    logic [abu_pkg::INT_W-1:0] int_stat_r;
    logic [abu_pkg::INT_W-1:0] int_stat_nxt;
    logic [abu_pkg::INT_W-1:0] int_mask_r;
    logic [abu_pkg::INT_W-1:0] int_mask_nxt;

    // Registered system outputs.
    logic [15:0] vector_r;
    logic [15:0] vector_nxt;
    logic wake_flag_r;
    logic wake_flag_nxt;

    logic wr_fire;
    logic wr_mapped;
    logic lane_ok;
    logic wr_scr;
    logic match;
    logic soft_break;
    logic trigger;
    logic load_soft_int;
    logic in_break;
    logic request;
    logic break_end;
    logic [abu_pkg::INT_W-1:0] int_events;

    // A write is carried out once both address and data are held.
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign lane_ok = wr_fire && w_lane_r;
    assign wr_mapped = abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_BP_HIGH)
                    || abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_BP_LOW)
                    || abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_STATUS_CTRL)
                    || abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_FLAG_CTRL)
                    || abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_INT_STATUS)
                    || abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_INT_MASK);
    assign wr_scr = lane_ok
                 && abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_STATUS_CTRL);

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = {24'h000000, rdata_r};

    abu_addr_cmp u_cmp (
        .cpu(cpu),
        .bp_addr({bp_high_r, bp_low_r}),
        .enable(enable_r),
        .match(match)
    );

    // Writing one to the active bit is itself a break request.
    assign soft_break = wr_scr && w_data_r[abu_pkg::SCR_ACTIVE_BIT];
    assign trigger = match || soft_break;

    abu_break_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .trigger(trigger),
        .cpu(cpu),
        .sys(sys),
        .load_soft_int(load_soft_int),
        .in_break(in_break),
        .request(request),
        .break_end(break_end)
    );

    // Bus write channel group.
    always_comb begin
        aw_have_nxt = aw_have_r;
        aw_addr_nxt = aw_addr_r;
        w_have_nxt = w_have_r;
        w_data_nxt = w_data_r;
        w_lane_nxt = w_lane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata[7:0];
            w_lane_nxt = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_mapped ? abu_pkg::RESP_OKAY : abu_pkg::RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_have_r <= 1'b0;
            w_data_r <= abu_pkg::RST_BYTE;
            w_lane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= abu_pkg::RESP_OKAY;
        end else begin
            aw_have_r <= aw_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_have_r <= w_have_nxt;
            w_data_r <= w_data_nxt;
            w_lane_r <= w_lane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // Bus read channel group; reads have no side effects.
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = abu_pkg::RESP_OKAY;
            rdata_nxt = abu_pkg::RST_BYTE;
            if (abu_pkg::reg_hit(s_axi_araddr, abu_pkg::IDX_BP_HIGH)) begin
                rdata_nxt = bp_high_r;
            end else if (abu_pkg::reg_hit(s_axi_araddr,
                                          abu_pkg::IDX_BP_LOW)) begin
                rdata_nxt = bp_low_r;
            end else if (abu_pkg::reg_hit(s_axi_araddr,
                                          abu_pkg::IDX_STATUS_CTRL)) begin
                rdata_nxt = {enable_r, active_r, 6'h00};
            end else if (abu_pkg::reg_hit(s_axi_araddr,
                                          abu_pkg::IDX_FLAG_CTRL)) begin
                rdata_nxt = {clear_en_r, 7'h00};
            end else if (abu_pkg::reg_hit(s_axi_araddr,
                                          abu_pkg::IDX_INT_STATUS)) begin
                rdata_nxt = {5'h00, int_stat_r};
            end else if (abu_pkg::reg_hit(s_axi_araddr,
                                          abu_pkg::IDX_INT_MASK)) begin
                rdata_nxt = {5'h00, int_mask_r};
            end else begin
                rresp_nxt = abu_pkg::RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= abu_pkg::RST_BYTE;
            rresp_r <= abu_pkg::RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign int_events[abu_pkg::INT_MATCH_BIT] = match;
    assign int_events[abu_pkg::INT_SOFT_BIT] = soft_break;
    assign int_events[abu_pkg::INT_END_BIT] = break_end;

    // Register file group.
    always_comb begin
        bp_high_nxt = bp_high_r;
        bp_low_nxt = bp_low_r;
        enable_nxt = enable_r;
        active_nxt = active_r;
        clear_en_nxt = clear_en_r;
        int_stat_nxt = int_stat_r;
        int_mask_nxt = int_mask_r;
        if (lane_ok && abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_BP_HIGH)) begin
            bp_high_nxt = w_data_r;
        end
        if (lane_ok && abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_BP_LOW)) begin
            bp_low_nxt = w_data_r;
        end
        if (wr_scr) begin
            enable_nxt = w_data_r[abu_pkg::SCR_ENABLE_BIT];
            active_nxt = w_data_r[abu_pkg::SCR_ACTIVE_BIT];
        end
        // A match in the same cycle as a clearing write still leaves it set.
        if (match) begin
            active_nxt = 1'b1;
        end
        if (lane_ok
            && abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_FLAG_CTRL)) begin
            clear_en_nxt = w_data_r[abu_pkg::FLAG_CLEAR_EN_BIT];
        end
        if (lane_ok
            && abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_INT_MASK)) begin
            int_mask_nxt = w_data_r[abu_pkg::INT_W-1:0];
        end
        // Clearing applies its own block flags, so it honours the clear gate.
        if (lane_ok && (!in_break || clear_en_r)
            && abu_pkg::reg_hit(aw_addr_r, abu_pkg::IDX_INT_STATUS)) begin
            int_stat_nxt = int_stat_r & ~w_data_r[abu_pkg::INT_W-1:0];
        end
        int_stat_nxt = int_stat_nxt | int_events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bp_high_r <= abu_pkg::RST_BYTE;
            bp_low_r <= abu_pkg::RST_BYTE;
            enable_r <= 1'b0;
            active_r <= 1'b0;
            clear_en_r <= 1'b0;
            int_stat_r <= abu_pkg::RST_INT;
            int_mask_r <= abu_pkg::RST_INT;
        end else begin
            bp_high_r <= bp_high_nxt;
            bp_low_r <= bp_low_nxt;
            enable_r <= enable_nxt;
            active_r <= active_nxt;
            clear_en_r <= clear_en_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
        end
    end

    // System output group. The vector follows the mode one cycle late;
    // monitor mode is fixed well before any break can be taken.
    always_comb begin
        vector_nxt = sys.monitor_mode ? abu_pkg::VEC_MONITOR
                                      : abu_pkg::VEC_USER;
        wake_flag_nxt = load_soft_int && sys.low_power;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_r <= abu_pkg::VEC_USER;
            wake_flag_r <= 1'b0;
        end else begin
            vector_r <= vector_nxt;
            wake_flag_r <= wake_flag_nxt;
        end
    end

    always_comb begin
        sys_out.breakpoint_request = request;
        sys_out.load_soft_int = load_soft_int;
        sys_out.vector_addr = vector_r;
        sys_out.break_state = in_break;
        sys_out.timer_stop = in_break;
        sys_out.watchdog_disable = in_break && sys.hv_reset_pin;
        sys_out.flag_clear_allowed = in_break && clear_en_r;
        sys_out.wake_request = (load_soft_int || in_break)
                             && sys.low_power;
        sys_out.break_wakeup_flag_set = wake_flag_r;
    end

    assign irq = |(int_stat_r & int_mask_r);
endmodule

// >>> sim/abu_chk.sv
// Assertion checker for the breakpoint unit, bound to its top module.
module abu_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire abu_pkg::abu_cpu_t cpu,
    input wire abu_pkg::abu_sys_t sys,
    input wire abu_pkg::abu_sys_out_t sys_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_start;
        sys_out.load_soft_int ##1 sys_out.break_state;
    endsequence
    sequence s_mon2;
        sys.monitor_mode ##1 sys.monitor_mode;
    endsequence
    a_load_req: assert property (sys_out.load_soft_int |->
        sys_out.breakpoint_request) else $error("load without request");
    a_load_edge: assert property (sys_out.load_soft_int |->
        cpu.instr_last || sys.low_power) else $error("load mid instruction");
    a_break_start: assert property (sys_out.load_soft_int |->
        s_start) else $error("break did not start after load");
    a_pend_hold: assert property (sys_out.breakpoint_request &&
        !sys_out.load_soft_int && !sys_out.break_state |=>
        sys_out.breakpoint_request) else $error("pending request lost");
    a_timer_stop: assert property (sys_out.timer_stop ==
        sys_out.break_state) else $error("timer not held in break");
    a_wdog_off: assert property (sys_out.watchdog_disable ==
        (sys_out.break_state && sys.hv_reset_pin))
        else $error("watchdog disable wrong");
    a_rti_end: assert property (sys_out.break_state && cpu.rti_exec
        |=> !sys_out.break_state) else $error("return did not end break");
    a_break_stay: assert property (sys_out.break_state &&
        !cpu.rti_exec |=> sys_out.break_state) else $error("break left early");
    a_vec_mon: assert property (s_mon2 |->
        sys_out.vector_addr == abu_pkg::VEC_MONITOR)
        else $error("monitor vector wrong");
    a_wake_flag: assert property (sys_out.load_soft_int &&
        sys.low_power |=> sys_out.break_wakeup_flag_set)
        else $error("wakeup flag not set");
    a_flag_gate: assert property (sys_out.flag_clear_allowed |->
        sys_out.break_state) else $error("flag clear outside break");
endmodule
bind abu_top abu_chk chk_u (.aclk(aclk), .aresetn(aresetn), .cpu(cpu),
    .sys(sys), .sys_out(sys_out));

// >>> sim/abu_cpu_model.sv
// Behavioural core model: fetches, instruction ends and break return.
module abu_cpu_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic hold,
    input wire logic [1:0] ilen,
    input wire logic [15:0] pc0,
    input wire abu_pkg::abu_sys_out_t so,
    output abu_pkg::abu_cpu_t cpu
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] pc;
    logic [1:0] cyc;
    int bk;
    // Operand cycles show the inverted pc as a non-fetch address, never the pc itself.
    assign cpu.addr = (cyc == 2'h0) ? pc : ~pc;
    assign cpu.addr_valid = run && cyc == 2'h0 && !so.break_state;
    assign cpu.instr_last = run && cyc == ilen;
    assign cpu.rti_exec = so.break_state && bk >= 4 && !hold;
    always @(posedge aclk) begin
        bk <= so.break_state ? bk + 1 : 0;
        if (!aresetn || !run) begin
            cyc <= 2'h0;
            pc <= pc0;
        end else if (!so.break_state && !so.load_soft_int) begin
            cyc <= (cyc == ilen) ? 2'h0 : cyc + 2'h1;
            if (cyc == ilen) pc <= pc + 16'h1;
        end
    end
endmodule

// >>> sim/address_breakpoint_unit_test.sv
// Self-checking bench for the breakpoint unit with a reference model.
module address_breakpoint_unit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [17:0] awaddr = 18'h0;
    logic [17:0] araddr = 18'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    abu_pkg::abu_cpu_t cpu;
    abu_pkg::abu_sys_t sys = 3'h0;
    abu_pkg::abu_sys_out_t sys_out;
    logic run = 1'b0, hold = 1'b0, lst;
    logic [1:0] ilen = 2'h0;
    logic [15:0] pc0 = 16'h0, bp;
    int fails = 0, comparisons = 0, hit, at;
    int mdl[int];
    localparam logic [15:0] SCR = abu_pkg::IDX_STATUS_CTRL;
    localparam logic [15:0] IST = abu_pkg::IDX_INT_STATUS;
    localparam logic [15:0] MSK = abu_pkg::IDX_INT_MASK;
    abu_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready), .cpu(cpu),
        .sys(sys), .sys_out(sys_out), .irq(irq));
    abu_cpu_model cpu_u (.aclk(aclk), .aresetn(aresetn), .run(run),
        .hold(hold), .ilen(ilen), .pc0(pc0), .so(sys_out), .cpu(cpu));
    initial begin
        forever #50 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] ix, input logic [7:0] d,
        input logic [1:0] e);
        logic a, w, da, dw;
        logic [1:0] r;
        da = 1'b0;
        dw = 1'b0;
        awaddr <= {ix, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            a = awvalid && s_axi_awready;
            w = wvalid && s_axi_wready;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            da = da | a;
            dw = dw | w;
        end while (!(da && dw));
        do begin
            @(negedge aclk);
            a = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end while (!a);
        bready <= 1'b0;
        chk(r, e);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [15:0] ix, input logic [31:0] e,
        input logic [1:0] er);
        logic a;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            a = s_axi_arready;
            @(posedge aclk);
        end while (!a);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            a = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (!a);
        rready <= 1'b0;
        chk(d, e);
        chk(r, er);
        @(posedge aclk);
    endtask
    task automatic rc(input logic [15:0] ix);
        rd(ix, mdl[ix], abu_pkg::RESP_OKAY);
    endtask
    task automatic mw(input logic [15:0] ix, input logic [7:0] d, int m);
        wr(ix, d, abu_pkg::RESP_OKAY);
        mdl[ix] = d & m;
    endtask
    // Runs the core from pc0 and notes the fetch of bp and the opcode load.
    task automatic catch_break(input logic [1:0] n, input logic [15:0] p);
        ilen <= n;
        pc0 <= p;
        @(posedge aclk);
        run <= 1'b1;
        at = -1;
        hit = -1;
        for (int i = 0; i < 40 && at < 0; i++) begin
            @(negedge aclk);
            if (cpu.addr_valid && cpu.addr === bp) hit = i;
            if (sys_out.load_soft_int === 1'b1) at = i;
            lst = cpu.instr_last;
        end
        @(posedge aclk);
        run <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge aclk);
        fails++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'hDCCCED61));
        for (int i = 0; i < 7; i++) mdl[16'hFE0C + i] = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 7; i++) begin
            if (i != 3) rc(16'hFE0C + i);
        end
        rd(16'hFE0F, 32'h0, abu_pkg::RESP_SLVERR);
        wr(16'hFE0F, 8'hFF, abu_pkg::RESP_SLVERR);
        bp = 16'h0100 + $urandom_range(16'hFD00);
        mw(abu_pkg::IDX_BP_HIGH, bp[15:8], 255);
        mw(abu_pkg::IDX_BP_LOW, bp[7:0], 255);
        rc(abu_pkg::IDX_BP_HIGH);
        rc(abu_pkg::IDX_BP_LOW);
        catch_break(2'h0, bp - 16'h3);
        chk(at, -1);
        @(posedge aclk);
        mw(SCR, 8'h80, 8'hC0);
        catch_break(2'h0, bp - 16'h3);
        chk(at, hit);
        chk(sys_out.break_state, 1'b1);
        chk(sys_out.timer_stop, 1'b1);
        chk(sys_out.vector_addr, abu_pkg::VEC_USER);
        repeat (10) @(posedge aclk);
        chk(sys_out.break_state, 1'b0);
        mdl[SCR] = 8'hC0;
        mdl[IST] = 5;
        rc(SCR);
        rc(IST);
        mw(SCR, 8'h80, 8'hC0);
        rc(SCR);
        mw(IST, 8'h07, 0);
        sys <= 3'b110;
        catch_break(2'h2, bp - 16'h2);
        chk(at - hit, 2);
        chk(lst, 1'b1);
        chk(sys_out.vector_addr, abu_pkg::VEC_MONITOR);
        chk(sys_out.watchdog_disable, 1'b1);
        repeat (10) @(posedge aclk);
        mw(SCR, 8'h80, 8'hC0);
        mw(IST, 8'h07, 0);
        mw(abu_pkg::IDX_BP_HIGH, bp[15:8] ^ 8'h80, 255);
        catch_break(2'h0, bp - 16'h3);
        chk(at, -1);
        @(posedge aclk);
        hold <= 1'b1;
        sys <= 3'b001;
        mw(SCR, 8'hFF, 8'hC0);
        mdl[IST] = 2;
        chk(sys_out.break_state, 1'b1);
        chk(sys_out.wake_request, 1'b1);
        rc(SCR);
        wr(IST, 8'h07, abu_pkg::RESP_OKAY);
        rc(IST);
        mw(abu_pkg::IDX_FLAG_CTRL, 8'hFF, 8'h80);
        rc(abu_pkg::IDX_FLAG_CTRL);
        chk(sys_out.flag_clear_allowed, 1'b1);
        mw(IST, 8'h07, 0);
        rc(IST);
        hold <= 1'b0;
        repeat (10) @(posedge aclk);
        mdl[IST] = 4;
        mw(MSK, 8'hFF, 7);
        rc(MSK);
        chk(irq, 1'b1);
        mw(MSK, 8'h03, 7);
        chk(irq, 1'b0);
        rc(IST);
        give_verdict;
    end
endmodule
